//--- rtl/request_engine.sv
// Summary of operation
// [RULE_01] at most three servers, one per connection
// [RULE_02] timeout 100 to 25500 ms, 100 ms steps
// [RULE_03] timeout runs from send to response
// [RULE_04] trigger bits consecutive, first is request 1
// [RULE_05] program sets trigger bit to send request
// [RULE_06] engine clears trigger bit on completion
// [RULE_07] program sets bit again for repeated sends
// [RULE_08] no triggers: all requests run continuously
// [RULE_09] error only after three failed attempts
// [RULE_10] errored request dropped, next one follows
// [RULE_11] per-request mode: one word per request
// [RULE_12] shared mode: one word, overwritten each time
// [RULE_13] word holds host high, code low
// [RULE_14] codes 00h ok, 01h bad function
// [RULE_15] codes 02h address, 03h quantity error
// [RULE_16] codes 12h frame length, 13h check error
// [RULE_17] codes 14h unit number, 16h timeout
// [RULE_18] table holds at most 255 requests
// [RULE_19] error words follow table order
// [RULE_20] requests advance at scan end, ascending
// [RULE_21] one outstanding request per connection
`timescale 1ns/1ps
`default_nettype none
module request_engine #(
   parameter int STEP_CYCLES = engine_pkg::STEP_CYCLES
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_B,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic PREADY,
   output logic [31:0] PRDATA,
   output logic PSLVERR,
   // program scan
   input wire logic SCAN_END,
   // connection side
   output logic REQ_VALID,
   output logic [1:0] REQ_CONN,
   output logic [7:0] REQ_HOST,
   output logic [7:0] REQ_INDEX,
   input wire logic RSP_VALID,
   input wire logic [1:0] RSP_CONN,
   input wire logic [7:0] RSP_CODE,
   // status
   output logic BUSY
);
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic enable_reg, shared_reg, trig_mode_reg;
   logic [7:0] count_reg, tout_reg;
   logic [254:0] trig_reg;
   logic [7:0] host_reg [engine_pkg::NUM_REQ];
   logic [1:0] conn_reg [engine_pkg::NUM_REQ];
   logic [15:0] word_store_cell [engine_pkg::NUM_REQ];
   logic [15:0] shared_word_reg;
   engine_pkg::seq_state_t state_reg;
   logic [7:0] idx_reg, vis_reg;
   logic [1:0] try_reg;
   logic step_tick, expired;

   function automatic logic [7:0] slot(input logic [11:0] a);
      return a[9:2];
   endfunction

   function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo,
                                     input logic [11:0] hi);
      return (a >= lo) && (a <= hi) && (a[1:0] == 2'h0);
   endfunction

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic setup, wr_now;
   logic is_trig, is_tab, is_err, is_fix, hit;
   logic [7:0] ps;
   logic [31:0] rdata_next;
   assign setup = PSEL && !PENABLE && !PREADY;
   assign wr_now = PSEL && PENABLE && PREADY && PWRITE;
   assign ps = slot(PADDR);
   assign is_trig = in_range(PADDR, engine_pkg::TRIG_OFS, engine_pkg::TRIG_END);
   assign is_tab = in_range(PADDR, engine_pkg::TABLE_OFS, 12'h7ff) && ps != 8'hff;
   assign is_err = in_range(PADDR, engine_pkg::ERRW_OFS, engine_pkg::ERRW_END);
   assign is_fix = PADDR == engine_pkg::CTRL_OFS || PADDR == engine_pkg::TOUT_OFS ||
                   PADDR == engine_pkg::STAT_OFS || PADDR == engine_pkg::SERR_OFS;
   assign hit = is_trig || is_tab || is_err || is_fix;

   always_comb begin
      rdata_next = 32'h0;
      if (is_trig) begin
         rdata_next = 32'({1'b0, trig_reg} >> {PADDR[4:2], 5'h0});
      end else if (is_tab) begin
         rdata_next = {22'h0, conn_reg[ps], host_reg[ps]};
      end else if (is_err) begin
         rdata_next = {16'h0, word_store_cell[ps]};
      end else if (PADDR == engine_pkg::CTRL_OFS) begin
         rdata_next = {16'h0, count_reg, 5'h0, trig_mode_reg, shared_reg, enable_reg};
      end else if (PADDR == engine_pkg::TOUT_OFS) begin
         rdata_next = {24'h0, tout_reg};
      end else if (PADDR == engine_pkg::STAT_OFS) begin
         rdata_next = {12'h0, state_reg, 6'h0, try_reg, idx_reg};
      end else if (PADDR == engine_pkg::SERR_OFS) begin
         rdata_next = {16'h0, shared_word_reg};
      end
   end

   // one wait-free access cycle: ready rises right after setup
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= setup;
         PSLVERR <= setup && !hit;
         if (setup) begin
            PRDATA <= PWRITE ? 32'h0 : rdata_next;
         end
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         enable_reg <= 1'b0;
         shared_reg <= 1'b0;
         trig_mode_reg <= 1'b0;
         count_reg <= engine_pkg::CNT_RST;
         tout_reg <= engine_pkg::TOUT_RST;
      end else if (wr_now && PADDR == engine_pkg::CTRL_OFS) begin
         enable_reg <= PWDATA[engine_pkg::CTRL_EN_BIT];
         shared_reg <= PWDATA[engine_pkg::CTRL_SHARED_BIT];
         trig_mode_reg <= PWDATA[engine_pkg::CTRL_TRIG_BIT];
         // an 8-bit count cannot pass 255; zero would leave no request
         count_reg <= PWDATA[15:8] == 8'h0 ? 8'h1 : PWDATA[15:8]; // RULE_18
      end else if (wr_now && PADDR == engine_pkg::TOUT_OFS) begin
         tout_reg <= PWDATA[7:0] < engine_pkg::TOUT_MIN ? engine_pkg::TOUT_MIN
                                                         : PWDATA[7:0]; // RULE_02
      end
   end

   // request table: host 0 is not a valid host, connection 3 does not exist
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int i = 0; i < engine_pkg::NUM_REQ; i++) begin
            host_reg[i] <= engine_pkg::HOST_MIN;
            conn_reg[i] <= 2'h0;
         end
      end else if (wr_now && is_tab) begin
         host_reg[ps] <= PWDATA[7:0] == 8'h0 ? engine_pkg::HOST_MIN : PWDATA[7:0]; // RULE_13
         conn_reg[ps] <= PWDATA[9:8] > engine_pkg::LAST_CONN ? engine_pkg::LAST_CONN
                                                             : PWDATA[9:8]; // RULE_01
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   logic rsp_mine, done, fail, elig;
   logic [7:0] code, idx_next;
   logic [15:0] result;
   assign rsp_mine = RSP_VALID && RSP_CONN == conn_reg[idx_reg];
   assign fail = expired || (rsp_mine && RSP_CODE != engine_pkg::CODE_OK);
   assign done = state_reg == engine_pkg::ST_WAIT && (expired || rsp_mine) &&
                 (!fail || try_reg == engine_pkg::LAST_TRY); // RULE_09
   assign code = expired ? engine_pkg::CODE_TMO : RSP_CODE; // RULE_14 RULE_15 RULE_16 RULE_17
   assign result = {host_reg[idx_reg], code}; // RULE_13
   assign elig = !trig_mode_reg || trig_reg[idx_reg]; // RULE_08 RULE_04
   assign idx_next = idx_reg >= count_reg - 8'h1 ? 8'h0 : idx_reg + 8'h1;

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_reg <= engine_pkg::ST_IDLE;
         idx_reg <= 8'h0;
         vis_reg <= 8'h0;
         try_reg <= 2'h0;
      end else begin
         unique case (state_reg)
            engine_pkg::ST_IDLE: begin
               if (SCAN_END && enable_reg) begin // RULE_20
                  state_reg <= engine_pkg::ST_SCAN;
                  vis_reg <= 8'h0;
                  if (idx_reg >= count_reg) begin
                     idx_reg <= 8'h0;
                  end
               end
            end
            engine_pkg::ST_SCAN: begin
               try_reg <= 2'h0;
               if (elig) begin
                  state_reg <= engine_pkg::ST_SEND;
               end else if (vis_reg == count_reg - 8'h1) begin
                  state_reg <= engine_pkg::ST_IDLE;
               end else begin
                  idx_reg <= idx_next; // RULE_20
                  vis_reg <= vis_reg + 8'h1;
               end
            end
            engine_pkg::ST_SEND: begin
               state_reg <= engine_pkg::ST_WAIT;
            end
            engine_pkg::ST_WAIT: begin
               // nothing else goes out until this one ends
               if (done) begin // RULE_21
                  state_reg <= engine_pkg::ST_IDLE;
                  idx_reg <= idx_next; // RULE_10
               end else if (fail) begin
                  state_reg <= engine_pkg::ST_SEND; // RULE_09
                  try_reg <= try_reg + 2'h1;
               end
            end
         endcase
      end
   end

   // launch pulse and request fields
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         REQ_VALID <= 1'b0;
         REQ_CONN <= 2'h0;
         REQ_HOST <= 8'h0;
         REQ_INDEX <= 8'h0;
         BUSY <= 1'b0;
      end else begin
         REQ_VALID <= state_reg == engine_pkg::ST_SEND;
         BUSY <= state_reg != engine_pkg::ST_IDLE;
         if (state_reg == engine_pkg::ST_SEND) begin
            REQ_CONN <= conn_reg[idx_reg]; // RULE_01
            REQ_HOST <= host_reg[idx_reg];
            REQ_INDEX <= idx_reg;
         end
      end
   end

   // trigger bits: bit i of the bank belongs to request i+1; a program write
   // lands after the completion clear so a set in the same cycle survives
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         trig_reg <= '0;
      end else begin
         for (int b = 0; b < engine_pkg::NUM_REQ; b++) begin
            if (wr_now && is_trig && 3'(b / 32) == PADDR[4:2]) begin
               trig_reg[b] <= PWDATA[b % 32]; // RULE_04 RULE_05 RULE_07
            end else if (done && idx_reg == 8'(b)) begin
               trig_reg[b] <= 1'b0; // RULE_06
            end
         end
      end
   end

   // result words, one per table slot or one shared
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int i = 0; i < engine_pkg::NUM_REQ; i++) begin
            word_store_cell[i] <= 16'h0;
         end
         shared_word_reg <= 16'h0;
      end else if (done) begin
         if (shared_reg) begin
            shared_word_reg <= result; // RULE_12
         end else begin
            word_store_cell[idx_reg] <= result; // RULE_11 RULE_19
         end
      end
   end

   // ------------------------------------------------------------
   // timeout
   // ------------------------------------------------------------
   step_divider #(
      .STEP_CYCLES(STEP_CYCLES)
   ) u_div (
      .CORE_CLK(CORE_CLK),
      .RST_B(RST_B),
      .step_tick(step_tick)
   );

   timeout_counter u_tmo (
      .CORE_CLK(CORE_CLK),
      .RST_B(RST_B),
      .start(state_reg == engine_pkg::ST_SEND), // RULE_03
      .stop(rsp_mine),
      .step_tick(step_tick),
      .steps(tout_reg),
      .expired(expired)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // attempts counted from the launch pulses, apart from the retry counter,
   // so the error decision is checked against what really went out
   logic [1:0] sent_reg;

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         sent_reg <= 2'h0;
      end else if (state_reg == engine_pkg::ST_SCAN) begin
         sent_reg <= 2'h0;
      end else if (REQ_VALID && sent_reg != 2'h3) begin
         sent_reg <= sent_reg + 2'h1;
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);

   a_conn_in_range: assert property (REQ_VALID |-> REQ_CONN < 2'h3) // RULE_01
      else $error("request on a connection that does not exist");
   a_tout_range: assert property (tout_reg >= engine_pkg::TOUT_MIN) // RULE_02
      else $error("timeout below one step");
   a_expire_in_wait: assert property (expired |-> state_reg == engine_pkg::ST_WAIT) // RULE_03
      else $error("timeout outside a wait");
   a_trig_gates_send: assert property ( // RULE_04
      state_reg == engine_pkg::ST_SEND && trig_mode_reg |-> trig_reg[idx_reg])
      else $error("request sent without its trigger bit");
   a_trig_cleared: assert property ( // RULE_06
      done && trig_mode_reg && !(wr_now && is_trig) |=> !trig_reg[$past(idx_reg)])
      else $error("trigger bit not cleared on completion");
   a_three_tries: assert property (done && fail |-> sent_reg == 2'h3) // RULE_09
      else $error("error declared before the third attempt");
   a_retry_early: assert property ( // RULE_09
      state_reg == engine_pkg::ST_WAIT && fail && !done |-> sent_reg != 2'h3)
      else $error("retry after the third attempt");
   a_own_word: assert property ( // RULE_11
      done && !shared_reg |=> word_store_cell[$past(idx_reg)] == $past(result))
      else $error("result word of the request not written");
   a_move_next: assert property (done |=> idx_reg == $past(idx_next)) // RULE_10
      else $error("sequencer did not move to the next request");
   a_shared_word: assert property ( // RULE_12
      done && shared_reg |=> shared_word_reg == $past(result))
      else $error("shared word not overwritten");
   a_single_send: assert property ( // RULE_21
      REQ_VALID |=> !REQ_VALID ##1 !REQ_VALID)
      else $error("second request while one is outstanding");
   a_host_nonzero: assert property (done |-> result[15:8] != 8'h0) // RULE_13
      else $error("host number zero in result");
endmodule
`default_nettype wire

//--- common/engine_pkg.sv
package engine_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int NUM_REQ = 255;
   localparam int NUM_CONN = 3;
   localparam logic [1:0] LAST_CONN = 2'h2;
   localparam logic [1:0] LAST_TRY = 2'h2;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] TOUT_OFS = 12'h004;
   localparam logic [11:0] STAT_OFS = 12'h008;
   localparam logic [11:0] SERR_OFS = 12'h00c;
   localparam logic [11:0] TRIG_OFS = 12'h040;
   localparam logic [11:0] TRIG_END = 12'h05c;
   localparam logic [11:0] TABLE_OFS = 12'h400;
   localparam logic [11:0] ERRW_OFS = 12'h800;
   localparam logic [11:0] ERRW_END = 12'hbf8;

   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_SHARED_BIT = 1;
   localparam int CTRL_TRIG_BIT = 2;
   localparam int CTRL_CNT_LSB = 8;
   localparam int TABLE_CONN_LSB = 8;
   localparam logic [7:0] CNT_RST = 8'hff;
   localparam logic [7:0] TOUT_RST = 8'h0a;
   localparam logic [7:0] TOUT_MIN = 8'h01;
   localparam logic [7:0] HOST_MIN = 8'h01;

   // ------------------------------------------------------------
   // timing: timeout counts in steps of 100 ms
   // ------------------------------------------------------------
   localparam int STEP_MS = 100;
   localparam int CLK_KHZ = 250000;
   localparam int STEP_CYCLES = STEP_MS * CLK_KHZ;

   // ------------------------------------------------------------
   // result codes
   // ------------------------------------------------------------
   localparam logic [7:0] CODE_OK = 8'h00;
   localparam logic [7:0] CODE_FUNC = 8'h01;
   localparam logic [7:0] CODE_ADDR = 8'h02;
   localparam logic [7:0] CODE_QTY = 8'h03;
   localparam logic [7:0] CODE_LEN = 8'h12;
   localparam logic [7:0] CODE_BCC = 8'h13;
   localparam logic [7:0] CODE_UNIT = 8'h14;
   localparam logic [7:0] CODE_TMO = 8'h16;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SCAN = 4'b0010,
      ST_SEND = 4'b0100,
      ST_WAIT = 4'b1000
   } seq_state_t;

endpackage

//--- rtl/step_divider.sv
`timescale 1ns/1ps
`default_nettype none
module step_divider #(
   parameter int STEP_CYCLES = engine_pkg::STEP_CYCLES
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_B,
   // step pulse
   output logic step_tick
);
   logic [31:0] cnt_reg;

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         cnt_reg <= 32'h0;
         step_tick <= 1'b0;
      end else if (cnt_reg == 32'(STEP_CYCLES - 1)) begin
         cnt_reg <= 32'h0;
         step_tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 32'h1;
         step_tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- rtl/timeout_counter.sv
`timescale 1ns/1ps
`default_nettype none
module timeout_counter (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_B,
   // control
   input wire logic start,
   input wire logic stop,
   input wire logic step_tick,
   input wire logic [7:0] steps,
   // result
   output logic expired
);
   logic [7:0] left_reg;
   logic run_reg;

   // the first step is partial, so the wait is steps-1 to steps periods
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         left_reg <= 8'h0;
         run_reg <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (start) begin
            left_reg <= steps;
            run_reg <= 1'b1;
         end else if (stop) begin
            run_reg <= 1'b0;
         end else if (run_reg && step_tick) begin
            if (left_reg == 8'h1) begin
               run_reg <= 1'b0;
               expired <= 1'b1;
            end
            left_reg <= left_reg - 8'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- verification/server_model.sv
`timescale 1ns/1ps
`default_nettype none
module server_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // request side
   input wire logic req_valid,
   input wire logic [1:0] req_conn,
   // behaviour chosen by the bench
   input wire logic arm,
   input wire logic [1:0] fail_n,
   input wire logic [7:0] fail_code,
   input wire logic silent,
   input wire logic [7:0] delay,
   // response side
   output logic rsp_valid,
   output logic [1:0] rsp_conn,
   output logic [7:0] rsp_code,
   output logic [7:0] tries,
   output logic [7:0] overlap
);
   // ------------------------------------------------------------
   // one server shared by all connections, answering after a delay
   // ------------------------------------------------------------
   logic busy_reg;
   logic [7:0] wait_reg;
   logic [1:0] conn_reg;
   logic failing;

   // the first fail_n attempts after arm fail, later ones succeed
   assign failing = (tries <= {6'h00, fail_n});

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_reg <= 1'b0;
         wait_reg <= 8'h00;
         conn_reg <= 2'h0;
         tries <= 8'h00;
         overlap <= 8'h00;
         rsp_valid <= 1'b0;
         rsp_conn <= 2'h0;
         rsp_code <= 8'h00;
      end else begin
         rsp_valid <= 1'b0;
         // released lines toggle so a stale value is never mistaken for data
         rsp_code <= ~rsp_code;
         rsp_conn <= ~rsp_conn;
         if (arm) begin
            tries <= 8'h00;
         end
         if (req_valid) begin
            if (busy_reg) begin
               overlap <= overlap + 8'h01;
            end
            busy_reg <= 1'b1;
            wait_reg <= delay;
            conn_reg <= req_conn;
            tries <= tries + 8'h01;
         end else if (busy_reg) begin
            if (wait_reg > 8'h01) begin
               wait_reg <= wait_reg - 8'h01;
            end else begin
               busy_reg <= 1'b0;
               // a silent failure leaves the client to its timeout
               if (!(silent && failing)) begin
                  rsp_valid <= 1'b1;
                  rsp_conn <= conn_reg;
                  rsp_code <= failing ? fail_code : 8'h00;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- verification/modbus_tcp_client_request_engine_bench.sv
`timescale 1ns/1ps
`default_nettype none
module modbus_tcp_client_request_engine_bench;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, scan_end;
   logic req_valid, rsp_valid, busy, arm, silent, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] req_conn, rsp_conn, fail_n, seen_conn;
   logic [7:0] req_host, req_index, rsp_code, fail_code, delay, tries, overlap;
   logic [7:0] seen_idx, seen_host;
   logic [7:0] host [3];
   int mismatches, n_tests, n_req;
   logic [7:0] case_code [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h12, 8'h13, 8'h14, 8'h00, 8'h13};
   logic [1:0] case_fails [9] = '{2'h0, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2};
   logic case_silent [9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

   request_engine #(.STEP_CYCLES(20)) uut (
      .CORE_CLK(core_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
      .PRDATA(prdata), .PSLVERR(pslverr), .SCAN_END(scan_end),
      .REQ_VALID(req_valid), .REQ_CONN(req_conn), .REQ_HOST(req_host),
      .REQ_INDEX(req_index), .RSP_VALID(rsp_valid), .RSP_CONN(rsp_conn),
      .RSP_CODE(rsp_code), .BUSY(busy));

   server_model srv (
      .clk(core_clk), .rst_b(rst_b), .req_valid(req_valid), .req_conn(req_conn),
      .arm(arm), .fail_n(fail_n), .fail_code(fail_code), .silent(silent),
      .delay(delay), .rsp_valid(rsp_valid), .rsp_conn(rsp_conn),
      .rsp_code(rsp_code), .tries(tries), .overlap(overlap));

   always #2 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      if (req_valid === 1'b1) begin
         n_req++;
         seen_idx = req_index;
         seen_host = req_host;
         seen_conn = req_conn;
      end
   end

   // ------------------------------------------------------------
   // expectations
   // ------------------------------------------------------------
   function automatic logic [7:0] exp_code(input int i);
      if (case_fails[i] != 2'h3) return 8'h00;
      return case_silent[i] ? engine_pkg::CODE_TMO : case_code[i];
   endfunction

   function automatic logic [7:0] exp_tries(input int i);
      return (case_fails[i] == 2'h3) ? 8'h03 : 8'(case_fails[i]) + 8'h01;
   endfunction

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // an idle cycle follows each transfer, so no signal is driven twice in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) mismatches++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask

   task automatic set_server(input logic [1:0] fn, input logic [7:0] code, input logic sil);
      fail_n <= fn;
      fail_code <= code;
      silent <= sil;
      delay <= 8'($urandom_range(4, 1));
      arm <= 1'b1;
      @(posedge core_clk);
      arm <= 1'b0;
   endtask

   task automatic run_scan();
      int n;
      scan_end <= 1'b1;
      @(posedge core_clk);
      scan_end <= 1'b0;
      repeat (4) @(posedge core_clk);
      n = 0;
      while (busy !== 1'b0 && n < 600) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 600) mismatches++;
      @(posedge core_clk);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      #200000;
      mismatches++;
      give_verdict();
   end

   initial begin
      core_clk = 1'b0;
      rst_b = 1'b0;
      {psel, penable, pwrite, scan_end, arm, silent} = '0;
      paddr = '0;
      pwdata = '0;
      fail_n = '0;
      fail_code = '0;
      delay = 8'h01;
      mismatches = 0;
      n_tests = 0;
      n_req = 0;
      rd = $urandom(43);
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      rd_chk(engine_pkg::CTRL_OFS, 32'h0000ff00);
      rd_chk(engine_pkg::TOUT_OFS, 32'h0000000a);
      rd_chk(engine_pkg::ERRW_END, 32'h0);
      rd_chk(engine_pkg::TABLE_OFS + 12'h3f8, 32'h1);
      rd_chk(engine_pkg::ERRW_END + 12'h004, 32'h0);
      check({31'h0, err}, 32'h1);
      apb(1'b1, engine_pkg::TOUT_OFS, 32'h0);
      rd_chk(engine_pkg::TOUT_OFS, 32'h1);
      apb(1'b1, engine_pkg::TABLE_OFS, 32'h300);
      rd_chk(engine_pkg::TABLE_OFS, 32'h201);
      apb(1'b1, engine_pkg::TOUT_OFS, 32'h2);
      for (int s = 0; s < 3; s++) begin
         host[s] = 8'($urandom_range(255, 1));
         apb(1'b1, engine_pkg::TABLE_OFS + 12'(4 * s), {22'h0, 2'(s), host[s]});
      end
      apb(1'b1, engine_pkg::CTRL_OFS, 32'h00000301);
      // continuous mode walks the slots in order, one per scan
      for (int i = 0; i < 9; i++) begin
         set_server(case_fails[i], case_code[i], case_silent[i]);
         run_scan();
         check(32'(seen_idx), 32'(i % 3));
         check(32'(seen_host), 32'(host[i % 3]));
         check(32'(seen_conn), 32'(i % 3));
         check(32'(tries), 32'(exp_tries(i)));
         rd_chk(engine_pkg::ERRW_OFS + 12'(4 * (i % 3)), {16'h0, host[i % 3], exp_code(i)});
      end
      apb(1'b1, engine_pkg::CTRL_OFS, 32'h00000303);
      for (int i = 0; i < 2; i++) begin
         set_server(2'h3, i == 0 ? 8'h14 : 8'h03, 1'b0);
         run_scan();
         rd_chk(engine_pkg::SERR_OFS, {16'h0, host[i], i == 0 ? 8'h14 : 8'h03});
      end
      // trigger mode: nothing goes out until the program sets a bit
      apb(1'b1, engine_pkg::CTRL_OFS, 32'h00000305);
      set_server(2'h0, 8'h00, 1'b0);
      n_req = 0;
      run_scan();
      check(32'(n_req), 32'h0);
      apb(1'b1, engine_pkg::TRIG_OFS, 32'h4);
      run_scan();
      check(32'(n_req), 32'h1);
      check(32'(seen_idx), 32'h2);
      rd_chk(engine_pkg::TRIG_OFS, 32'h0);
      // a repeated send needs the program to set the bit again
      apb(1'b1, engine_pkg::TRIG_OFS, 32'h4);
      run_scan();
      check(32'(n_req), 32'h2);
      check(32'(overlap), 32'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
